/* design/cpuoag_regs.vh */
// Constants of the operand address generator: mode codes, opcode groups,
// prebytes and interrupt mask levels. Assumes an 8-bit opcode stream on a 64 Kbyte bus.
// Overview of operation
// - Seventeen addressing modes: inherent, immediate, direct, indexed, indirect, relative, bit.
// - Inherent instructions are one byte; no operand bytes are fetched.
// - Immediate instructions carry one operand value byte after the opcode.
// - Short direct takes one address byte, reaching 00 to FF.
// - Long direct takes two address bytes, reaching the whole 64 Kbyte space.
// - Indexed address is unsigned sum of selected index register and offset.
// - Indexed without offset fetches nothing; index alone gives 00 to FF.
// - Short indexed adds one offset byte to index, reaching 00 to 1FE.
// - Long indexed adds a 16-bit two-byte offset to the index.
// - Indirect forms take a page-zero pointer location from the byte after opcode.
// - Short indirect reads a byte pointer, giving 00 to FF.
// - Long indirect reads a word pointer at that location, full 64 Kbyte reach.
// - Indirect indexed adds the index register to the fetched pointer value.
// - Short indirect indexed: byte pointer plus index reaches 00 to 1FE.
// - Short forms use page-zero bases or pointers, reach at most 1FE, and use fewer bytes and cycles.
// - Long forms reach all 64 Kbyte, costing extra bytes and cycles.
// - Memory read-modify-write instructions decode only to short addressing forms.
// - Mask instruction sets interrupt level 3; unmask instruction sets level 0.
// - Relative forms add a signed 8-bit offset, direct or from memory.
// - Prebytes select second index, indirect forms, or second-index indirect indexed.
`ifndef CPUOAG_REGS_VH
`define CPUOAG_REGS_VH

// ******************************
// Addressing mode codes
// ******************************
`define OAG_M_INH 5'h00
`define OAG_M_IMM 5'h01
`define OAG_M_DIRS 5'h02
`define OAG_M_DIRL 5'h03
`define OAG_M_IDX0 5'h04
`define OAG_M_IDXS 5'h05
`define OAG_M_IDXL 5'h06
`define OAG_M_INDS 5'h07
`define OAG_M_INDL 5'h08
`define OAG_M_IIXS 5'h09
`define OAG_M_IIXL 5'h0a
`define OAG_M_RELD 5'h0b
`define OAG_M_RELI 5'h0c
`define OAG_M_BITD 5'h0d
`define OAG_M_BITI 5'h0e
`define OAG_M_BTRD 5'h0f
`define OAG_M_BTRI 5'h10

// ******************************
// Prebytes and their internal codes
// ******************************
`define OAG_SECOND_INDEX_PREBYTE 8'h90
`define OAG_SECOND_INDEX_INDIRECT_PREBYTE 8'h91
`define OAG_INDIRECT_PREBYTE 8'h92
`define OAG_PRE_NONE 2'h0
`define OAG_PRE_Y 2'h1
`define OAG_PRE_IND 2'h2
`define OAG_PRE_YIND 2'h3

// ******************************
// Opcode groups (upper nibble) and special opcodes
// ******************************
`define OAG_GRP_BTR 4'h0
`define OAG_GRP_BIT 4'h1
`define OAG_GRP_REL 4'h2
`define OAG_GRP_RMWDIR 4'h3
`define OAG_GRP_RMWIDXS 4'h6
`define OAG_GRP_RMWIDX0 4'h7
`define OAG_GRP_IMM 4'ha
`define OAG_GRP_DIRS 4'hb
`define OAG_GRP_DIRL 4'hc
`define OAG_GRP_IDXL 4'hd
`define OAG_GRP_IDXS 4'he
`define OAG_GRP_IDX0 4'hf
`define OAG_MASK_INTERRUPTS_OP 8'h9b
`define OAG_UNMASK_INTERRUPTS_OP 8'h9a
`define OAG_IMASK_LEVEL_SET 2'h3
`define OAG_IMASK_LEVEL_CLR 2'h0

`endif

/* design/cpuoag_ea_calc.v */
// Combinational effective address and relative target former.
// Assumes operand bytes, pointer and index are stable while read.
`timescale 1ns/1ps
`include "cpuoag_regs.vh"

module cpuoag_ea_calc (
   mode,
   opnd0,
   opnd1,
   ptrVal,
   idxVal,
   pcNext,
   effAddr,
   relTarget
);
   input wire [4:0] mode;
   input wire [7:0] opnd0;
   input wire [7:0] opnd1;
   input wire [15:0] ptrVal;
   input wire [7:0] idxVal;
   input wire [15:0] pcNext;
   output reg [15:0] effAddr;
   output reg [15:0] relTarget;

   reg [7:0] relOff;

   // Unsigned base plus index; short bases never carry past 1FE
   function [15:0] addIdx;
      input [15:0] base;
      input [7:0] idx;
      begin
         addIdx = base + {8'h00, idx};
      end
   endfunction

   always @* begin
      effAddr = 16'h0000;
      case (mode)
         `OAG_M_DIRS, `OAG_M_BITD, `OAG_M_BTRD: effAddr = {8'h00, opnd0};
         `OAG_M_DIRL: effAddr = {opnd0, opnd1};
         `OAG_M_IDX0: effAddr = {8'h00, idxVal};
         `OAG_M_IDXS: effAddr = addIdx({8'h00, opnd0}, idxVal);
         `OAG_M_IDXL: effAddr = addIdx({opnd0, opnd1}, idxVal);
         `OAG_M_INDS, `OAG_M_BITI, `OAG_M_BTRI: effAddr = {8'h00, ptrVal[7:0]};
         `OAG_M_INDL: effAddr = ptrVal;
         `OAG_M_IIXS: effAddr = addIdx({8'h00, ptrVal[7:0]}, idxVal);
         `OAG_M_IIXL: effAddr = addIdx(ptrVal, idxVal);
         default: effAddr = 16'h0000;
      endcase
   end

   always @* begin
      relOff = 8'h00;
      case (mode)
         `OAG_M_RELD: relOff = opnd0;
         `OAG_M_RELI: relOff = ptrVal[7:0];
         `OAG_M_BTRD, `OAG_M_BTRI: relOff = opnd1;
         default: relOff = 8'h00;
      endcase
      relTarget = pcNext + {{8{relOff[7]}}, relOff};
   end

endmodule

/* design/cpuoag_top.v */
// Operand addressing front end: prebyte and opcode fetch, operand and
// pointer fetch, effective address forming. Assumes a same-clock memory
// port that answers each held request with a one-cycle acknowledge.
`timescale 1ns/1ps
`include "cpuoag_regs.vh"

module cpuoag_top (
   sys_clk,
   rstn,
   startValid,
   startPc,
   idxX,
   idxY,
   memAck,
   memRdata,
   memReq,
   memAddr,
   busy,
   done,
   modeOut,
   opcodeOut,
   useY,
   operandVal,
   effAddr,
   relTarget,
   nextPc,
   instrLen,
   imaskWe,
   imaskLevel
);
   input wire sys_clk;
   input wire rstn;
   input wire startValid;
   input wire [15:0] startPc;
   input wire [7:0] idxX;
   input wire [7:0] idxY;
   input wire memAck;
   input wire [7:0] memRdata;
   output reg memReq;
   output reg [15:0] memAddr;
   output reg busy;
   output reg done;
   output reg [4:0] modeOut;
   output reg [7:0] opcodeOut;
   output reg useY;
   output reg [7:0] operandVal;
   output reg [15:0] effAddr;
   output reg [15:0] relTarget;
   output reg [15:0] nextPc;
   output reg [2:0] instrLen;
   output reg imaskWe;
   output reg [1:0] imaskLevel;

   // ******************************
   // States
   // ******************************
   localparam [4:0] S_IDLE = 5'b00001;
   localparam [4:0] S_OPC = 5'b00010;
   localparam [4:0] S_OPND = 5'b00100;
   localparam [4:0] S_PTR = 5'b01000;
   localparam [4:0] S_EA = 5'b10000;

   // ******************************
   // Decode functions
   // ******************************
   function [1:0] preCode;
      input [7:0] b;
      begin
         case (b)
            `OAG_SECOND_INDEX_PREBYTE: preCode = `OAG_PRE_Y;
            `OAG_INDIRECT_PREBYTE: preCode = `OAG_PRE_IND;
            `OAG_SECOND_INDEX_INDIRECT_PREBYTE: preCode = `OAG_PRE_YIND;
            default: preCode = `OAG_PRE_NONE;
         endcase
      end
   endfunction

   // Upper nibble selects the base mode; indirect prebytes lift it
   function [4:0] decMode;
      input [7:0] opc;
      input [1:0] pre;
      reg ind;
      begin
         ind = (pre == `OAG_PRE_IND) || (pre == `OAG_PRE_YIND);
         case (opc[7:4])
            `OAG_GRP_BTR: decMode = ind ? `OAG_M_BTRI : `OAG_M_BTRD;
            `OAG_GRP_BIT: decMode = ind ? `OAG_M_BITI : `OAG_M_BITD;
            `OAG_GRP_REL: decMode = ind ? `OAG_M_RELI : `OAG_M_RELD;
            // Memory RMW groups have only short forms
            `OAG_GRP_RMWDIR: decMode = ind ? `OAG_M_INDS : `OAG_M_DIRS;
            `OAG_GRP_RMWIDXS: decMode = ind ? `OAG_M_IIXS : `OAG_M_IDXS;
            `OAG_GRP_RMWIDX0: decMode = `OAG_M_IDX0;
            `OAG_GRP_IMM: decMode = `OAG_M_IMM;
            `OAG_GRP_DIRS: decMode = ind ? `OAG_M_INDS : `OAG_M_DIRS;
            `OAG_GRP_DIRL: decMode = ind ? `OAG_M_INDL : `OAG_M_DIRL;
            `OAG_GRP_IDXL: decMode = ind ? `OAG_M_IIXL : `OAG_M_IDXL;
            `OAG_GRP_IDXS: decMode = ind ? `OAG_M_IIXS : `OAG_M_IDXS;
            `OAG_GRP_IDX0: decMode = `OAG_M_IDX0;
            default: decMode = `OAG_M_INH;
         endcase
      end
   endfunction

   // Bytes that follow the opcode
   function [1:0] opndCnt;
      input [4:0] m;
      begin
         case (m)
            `OAG_M_INH, `OAG_M_IDX0: opndCnt = 2'd0;
            `OAG_M_DIRL, `OAG_M_IDXL: opndCnt = 2'd2;
            `OAG_M_BTRD, `OAG_M_BTRI: opndCnt = 2'd2;
            default: opndCnt = 2'd1;
         endcase
      end
   endfunction

   // Pointer bytes read from page zero, save a word pointer at FF, whose second byte is read from 0100
   function [1:0] ptrCnt;
      input [4:0] m;
      begin
         case (m)
            `OAG_M_INDL, `OAG_M_IIXL: ptrCnt = 2'd2;
            `OAG_M_INDS, `OAG_M_IIXS, `OAG_M_RELI: ptrCnt = 2'd1;
            `OAG_M_BITI, `OAG_M_BTRI: ptrCnt = 2'd1;
            default: ptrCnt = 2'd0;
         endcase
      end
   endfunction

   // ******************************
   // Reset release
   // ******************************
   reg [1:0] rstSyncQ;
   wire rstnInt;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstSyncQ <= 2'b00;
      end else begin
         rstSyncQ <= {rstSyncQ[0], 1'b1};
      end
   end

   assign rstnInt = rstSyncQ[1];

   // ******************************
   // Datapath state
   // ******************************
   reg [4:0] stQ;
   reg [15:0] pcQ;
   reg [15:0] basePcQ;
   reg [1:0] preQ;
   reg [7:0] opcQ;
   reg [4:0] modeQ;
   reg [7:0] opnd0Q;
   reg [7:0] opnd1Q;
   reg [1:0] opndLeftQ;
   reg firstQ;
   reg [1:0] ptrLeftQ;
   reg [15:0] ptrQ;
   wire [15:0] eaCalc;
   wire [15:0] relCalc;
   wire [7:0] idxSel;
   wire [1:0] newPre;
   wire [4:0] newMode;

   assign newPre = preCode(memRdata);
   assign newMode = decMode(memRdata, preQ);
   // Second index for both the index and the indirect-index prebytes
   assign idxSel = (preQ == `OAG_PRE_Y || preQ == `OAG_PRE_YIND) ? idxY : idxX;

   cpuoag_ea_calc u_ea (
      .mode(modeQ),
      .opnd0(opnd0Q),
      .opnd1(opnd1Q),
      .ptrVal(ptrQ),
      .idxVal(idxSel),
      .pcNext(pcQ),
      .effAddr(eaCalc),
      .relTarget(relCalc)
   );

   // ******************************
   // Fetch sequencer
   // ******************************
   always @(posedge sys_clk or negedge rstnInt) begin
      if (!rstnInt) begin
         stQ <= S_IDLE;
         pcQ <= 16'h0000;
         basePcQ <= 16'h0000;
         preQ <= `OAG_PRE_NONE;
         opcQ <= 8'h00;
         modeQ <= `OAG_M_INH;
         opnd0Q <= 8'h00;
         opnd1Q <= 8'h00;
         opndLeftQ <= 2'd0;
         firstQ <= 1'b0;
         ptrLeftQ <= 2'd0;
         ptrQ <= 16'h0000;
         memReq <= 1'b0;
         memAddr <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         modeOut <= `OAG_M_INH;
         opcodeOut <= 8'h00;
         useY <= 1'b0;
         operandVal <= 8'h00;
         effAddr <= 16'h0000;
         relTarget <= 16'h0000;
         nextPc <= 16'h0000;
         instrLen <= 3'd0;
         imaskWe <= 1'b0;
         imaskLevel <= `OAG_IMASK_LEVEL_CLR;
      end else begin
         done <= 1'b0;
         imaskWe <= 1'b0;
         case (stQ)
            S_IDLE: begin
               if (startValid) begin
                  stQ <= S_OPC;
                  pcQ <= startPc;
                  basePcQ <= startPc;
                  preQ <= `OAG_PRE_NONE;
                  opnd0Q <= 8'h00;
                  opnd1Q <= 8'h00;
                  ptrQ <= 16'h0000;
                  memReq <= 1'b1;
                  memAddr <= startPc;
                  busy <= 1'b1;
               end
            end
            S_OPC: begin
               if (memAck) begin
                  pcQ <= pcQ + 16'h0001;
                  memAddr <= pcQ + 16'h0001;
                  // Only one prebyte is honoured; a second one is an opcode
                  if (preQ == `OAG_PRE_NONE && newPre != `OAG_PRE_NONE) begin
                     preQ <= newPre;
                  end else begin
                     opcQ <= memRdata;
                     modeQ <= newMode;
                     opndLeftQ <= opndCnt(newMode);
                     ptrLeftQ <= ptrCnt(newMode);
                     firstQ <= 1'b1;
                     if (opndCnt(newMode) == 2'd0) begin
                        memReq <= 1'b0;
                        stQ <= S_EA;
                     end else begin
                        stQ <= S_OPND;
                     end
                  end
               end
            end
            S_OPND: begin
               if (memAck) begin
                  pcQ <= pcQ + 16'h0001;
                  memAddr <= pcQ + 16'h0001;
                  firstQ <= 1'b0;
                  opndLeftQ <= opndLeftQ - 2'd1;
                  // Long operands arrive high byte first
                  if (firstQ) begin
                     opnd0Q <= memRdata;
                  end else begin
                     opnd1Q <= memRdata;
                  end
                  if (opndLeftQ == 2'd1) begin
                     if (ptrLeftQ != 2'd0) begin
                        // Pointer sits in page zero at the first operand byte
                        memAddr <= {8'h00, firstQ ? memRdata : opnd0Q};
                        stQ <= S_PTR;
                     end else begin
                        memReq <= 1'b0;
                        stQ <= S_EA;
                     end
                  end
               end
            end
            S_PTR: begin
               if (memAck) begin
                  ptrLeftQ <= ptrLeftQ - 2'd1;
                  if (ptrLeftQ == 2'd2) begin
                     ptrQ[15:8] <= memRdata;
                     memAddr <= memAddr + 16'h0001;
                  end else begin
                     ptrQ[7:0] <= memRdata;
                     memReq <= 1'b0;
                     stQ <= S_EA;
                  end
               end
            end
            S_EA: begin
               effAddr <= eaCalc;
               relTarget <= relCalc;
               operandVal <= opnd0Q;
               modeOut <= modeQ;
               opcodeOut <= opcQ;
               useY <= (preQ == `OAG_PRE_Y) || (preQ == `OAG_PRE_YIND);
               nextPc <= pcQ;
               // Fits: at most one prebyte, one opcode, two operands
               instrLen <= pcQ[2:0] - basePcQ[2:0];
               if (modeQ == `OAG_M_INH && preQ == `OAG_PRE_NONE) begin
                  if (opcQ == `OAG_MASK_INTERRUPTS_OP) begin
                     imaskWe <= 1'b1;
                     imaskLevel <= `OAG_IMASK_LEVEL_SET;
                  end else if (opcQ == `OAG_UNMASK_INTERRUPTS_OP) begin
                     imaskWe <= 1'b1;
                     imaskLevel <= `OAG_IMASK_LEVEL_CLR;
                  end
               end
               done <= 1'b1;
               busy <= 1'b0;
               stQ <= S_IDLE;
            end
            default: begin
               stQ <= S_IDLE;
               memReq <= 1'b0;
               busy <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* testbench/cpuoag_top_monitor.sv */
// Port checker for the operand address generator.
// Assumes it is bound onto cpuoag_top and sees only that module's ports.
`timescale 1ns/1ps
`include "cpuoag_regs.vh"

module cpuoag_top_monitor (
   input wire sys_clk,
   input wire rstn,
   input wire startValid,
   input wire [15:0] startPc,
   input wire [7:0] idxX,
   input wire [7:0] idxY,
   input wire memAck,
   input wire [7:0] memRdata,
   input wire memReq,
   input wire [15:0] memAddr,
   input wire busy,
   input wire done,
   input wire [4:0] modeOut,
   input wire [7:0] opcodeOut,
   input wire useY,
   input wire [7:0] operandVal,
   input wire [15:0] effAddr,
   input wire [15:0] relTarget,
   input wire [15:0] nextPc,
   input wire [2:0] instrLen,
   input wire imaskWe,
   input wire [1:0] imaskLevel
);
   // ******************************
   // Port relations
   // ******************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
      else $error("read request moved before acknowledge");
   done_idle_a: assert property (done |-> !memReq && !busy ##1 !done)
      else $error("done while reading or longer than one cycle");
   start_busy_a: assert property (startValid && !busy && !done |=> busy [*2])
      else $error("accepted start not followed by busy");
   inh_ea_a: assert property (done && modeOut == `OAG_M_INH |-> effAddr == 16'h0000)
      else $error("inherent form produced an address");
   dirs_ea_a: assert property (done && modeOut == `OAG_M_DIRS |->
      effAddr == {8'h00, operandVal})
      else $error("short direct address wrong");
   idx0_ea_a: assert property (done && modeOut == `OAG_M_IDX0 |->
      effAddr == {8'h00, useY ? idxY : idxX})
      else $error("no-offset indexed address wrong");
   idxs_ea_a: assert property (done && modeOut == `OAG_M_IDXS |->
      effAddr == {8'h00, operandVal} + {8'h00, useY ? idxY : idxX})
      else $error("short indexed address wrong");
   inds_page_a: assert property (done && modeOut == `OAG_M_INDS |->
      effAddr[15:8] == 8'h00)
      else $error("short indirect left page zero");
   iixs_range_a: assert property (done && modeOut == `OAG_M_IIXS |->
      effAddr <= 16'h01fe)
      else $error("short indirect indexed beyond range");
   rel_target_a: assert property (done && modeOut == `OAG_M_RELD |->
      relTarget == nextPc + {{8{operandVal[7]}}, operandVal})
      else $error("relative target wrong");
   imask_lvl_a: assert property (imaskWe |->
      done && imaskLevel == (opcodeOut == `OAG_MASK_INTERRUPTS_OP ?
      `OAG_IMASK_LEVEL_SET : `OAG_IMASK_LEVEL_CLR))
      else $error("interrupt mask level wrong");
endmodule

bind cpuoag_top cpuoag_top_monitor u_cpuoag_top_monitor (
   .sys_clk(sys_clk), .rstn(rstn), .startValid(startValid), .startPc(startPc),
   .idxX(idxX), .idxY(idxY), .memAck(memAck), .memRdata(memRdata), .memReq(memReq),
   .memAddr(memAddr), .busy(busy), .done(done), .modeOut(modeOut), .opcodeOut(opcodeOut),
   .useY(useY), .operandVal(operandVal), .effAddr(effAddr), .relTarget(relTarget),
   .nextPc(nextPc), .instrLen(instrLen), .imaskWe(imaskWe), .imaskLevel(imaskLevel)
);

/* testbench/cpuoag_mem_model.sv */
// Byte-wide program and data memory with a settable wait count.
// Assumes the requester holds memReq and memAddr until memAck.
`timescale 1ns/1ps

module cpuoag_mem_model (
   input wire sys_clk,
   input wire rstn,
   input wire memReq,
   input wire [15:0] memAddr,
   input wire [3:0] waitCycles,
   output logic memAck,
   output logic [7:0] memRdata
);
   // ******************************
   // Storage and answer
   // ******************************
   logic [7:0] mem [0:65535];
   logic [3:0] waitCnt_q;
   logic [7:0] lastByte_q;

   initial begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'h00;
   end

   assign memAck = memReq && (waitCnt_q == waitCycles);
   // Outside an answer the bus shows the inverse, so stale data never matches
   assign memRdata = memAck ? mem[memAddr] : ~lastByte_q;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         waitCnt_q <= 4'h0;
         lastByte_q <= 8'h00;
      end else if (!memReq || memAck) begin
         waitCnt_q <= 4'h0;
         if (memAck)
            lastByte_q <= mem[memAddr];
      end else begin
         waitCnt_q <= waitCnt_q + 4'h1;
      end
   end
endmodule

/* testbench/cpu_operand_address_generator_test.sv */
// Self-checking bench: every addressing form decoded from memory.
// Assumes cpuoag_top, the memory model and the bound port checker.
`timescale 1ns/1ps
`include "cpuoag_regs.vh"

module cpu_operand_address_generator_test;
   typedef struct packed {
      logic [31:0] prog;
      logic [4:0] mode;
      logic [2:0] len;
      logic [15:0] ea;
      logic [7:0] rel;
      logic [7:0] x;
      logic [1:0] lvl;
   } cpuoag_row_t;

   logic sys_clk, rstn, startValid, memAck, memReq, busy, done, useY, imaskWe;
   logic [15:0] startPc, memAddr, effAddr, relTarget, nextPc;
   logic [7:0] idxX, idxY, memRdata, opcodeOut, operandVal;
   logic [4:0] modeOut;
   logic [2:0] instrLen;
   logic [1:0] imaskLevel;
   logic [3:0] waitCycles;
   int n_errors, checks_done;
   cpuoag_row_t rows [0:26];

   cpuoag_top u_cpuoag_top (.sys_clk(sys_clk), .rstn(rstn), .startValid(startValid),
      .startPc(startPc), .idxX(idxX), .idxY(idxY), .memAck(memAck), .memRdata(memRdata),
      .memReq(memReq), .memAddr(memAddr), .busy(busy), .done(done), .modeOut(modeOut),
      .opcodeOut(opcodeOut), .useY(useY), .operandVal(operandVal), .effAddr(effAddr),
      .relTarget(relTarget), .nextPc(nextPc), .instrLen(instrLen), .imaskWe(imaskWe),
      .imaskLevel(imaskLevel));
   cpuoag_mem_model u_cpuoag_mem_model (.sys_clk(sys_clk), .rstn(rstn), .memReq(memReq),
      .memAddr(memAddr), .waitCycles(waitCycles), .memAck(memAck), .memRdata(memRdata));

   // ******************************
   // Shared tasks
   // ******************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bump holds start for a second edge while busy, with another address; it must be ignored
   task automatic run_instr(input logic [15:0] pc, input cpuoag_row_t r, input bit bump);
      int k;
      logic [15:0] expRel;
      logic [7:0] expOpc;
      for (k = 0; k < r.len; k++)
         u_cpuoag_mem_model.mem[pc + k] = r.prog[31 - 8 * k -: 8];
      // Prebytes 90, 91 and 92 stand before the opcode
      expOpc = (r.prog[31:26] == 6'h24 && r.prog[25:24] != 2'h3) ?
         r.prog[23:16] : r.prog[31:24];
      @(negedge sys_clk);
      // Index moves only after the checker has seen the last result
      idxX = r.x;
      startPc = pc;
      startValid = 1'b1;
      @(negedge sys_clk);
      if (bump) begin
         startPc = pc + 16'h0100;
         @(negedge sys_clk);
      end
      startValid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 200) begin
         @(negedge sys_clk);
         k++;
      end
      check(k < 200, 1);
      expRel = pc + r.len + {{8{r.rel[7]}}, r.rel};
      check(modeOut, r.mode);
      check(instrLen, r.len);
      check(effAddr, r.ea);
      check(nextPc, pc + r.len);
      check(useY, r.prog[31:25] == 7'h48);
      check(opcodeOut, expOpc);
      check(imaskWe, r.prog[31:25] == 7'h4d && r.len == 3'h1);
      check(imaskLevel, r.lvl);
      if (r.mode == `OAG_M_IMM)
         check(operandVal, r.prog[23:16]);
      if (r.mode == `OAG_M_RELD || r.mode == `OAG_M_RELI || r.mode >= `OAG_M_BTRD)
         check(relTarget, expRel);
   endtask

   // ******************************
   // Clock, watchdog and sequence
   // ******************************
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      #100000;
      n_errors++;
      final_report;
   end

   initial begin
      rows = '{
         '{32'h9d000000, `OAG_M_INH, 3'h1, 16'h0000, 8'h00, 8'h21, 2'h0},
         '{32'ha6550000, `OAG_M_IMM, 3'h2, 16'h0000, 8'h00, 8'h21, 2'h0},
         '{32'hb6400000, `OAG_M_DIRS, 3'h2, 16'h0040, 8'h00, 8'h21, 2'h0},
         '{32'hc6123400, `OAG_M_DIRL, 3'h3, 16'h1234, 8'h00, 8'h21, 2'h0},
         '{32'hf6000000, `OAG_M_IDX0, 3'h1, 16'h0021, 8'h00, 8'h21, 2'h0},
         '{32'he6ff0000, `OAG_M_IDXS, 3'h2, 16'h01fe, 8'h00, 8'hff, 2'h0},
         '{32'hd6100000, `OAG_M_IDXL, 3'h3, 16'h1021, 8'h00, 8'h21, 2'h0},
         '{32'h92b64000, `OAG_M_INDS, 3'h3, 16'h0012, 8'h00, 8'h21, 2'h0},
         '{32'h9b000000, `OAG_M_INH, 3'h1, 16'h0000, 8'h00, 8'h21, 2'h3},
         '{32'h92c64000, `OAG_M_INDL, 3'h3, 16'h1234, 8'h00, 8'h21, 2'h3},
         '{32'h92c6ff00, `OAG_M_INDL, 3'h3, 16'h8077, 8'h00, 8'h21, 2'h3},
         '{32'h92e64000, `OAG_M_IIXS, 3'h3, 16'h0033, 8'h00, 8'h21, 2'h3},
         '{32'h92e65000, `OAG_M_IIXS, 3'h3, 16'h01fe, 8'h00, 8'hff, 2'h3},
         '{32'h92d64000, `OAG_M_IIXL, 3'h3, 16'h1255, 8'h00, 8'h21, 2'h3},
         '{32'h20fe0000, `OAG_M_RELD, 3'h2, 16'h0000, 8'hfe, 8'h21, 2'h3},
         '{32'h92204000, `OAG_M_RELI, 3'h3, 16'h0000, 8'h12, 8'h21, 2'h3},
         '{32'h10400000, `OAG_M_BITD, 3'h2, 16'h0040, 8'h00, 8'h21, 2'h3},
         '{32'h92104000, `OAG_M_BITI, 3'h3, 16'h0012, 8'h00, 8'h21, 2'h3},
         '{32'h00400500, `OAG_M_BTRD, 3'h3, 16'h0040, 8'h05, 8'h21, 2'h3},
         '{32'h92004005, `OAG_M_BTRI, 3'h4, 16'h0012, 8'h05, 8'h21, 2'h3},
         '{32'h90e61000, `OAG_M_IDXS, 3'h3, 16'h0015, 8'h00, 8'h21, 2'h3},
         '{32'h91e64000, `OAG_M_IIXS, 3'h3, 16'h0017, 8'h00, 8'h21, 2'h3},
         '{32'h3c400000, `OAG_M_DIRS, 3'h2, 16'h0040, 8'h00, 8'h21, 2'h3},
         '{32'h7c000000, `OAG_M_IDX0, 3'h1, 16'h0021, 8'h00, 8'h21, 2'h3},
         '{32'h6cff0000, `OAG_M_IDXS, 3'h2, 16'h0120, 8'h00, 8'h21, 2'h3},
         '{32'h92f60000, `OAG_M_IDX0, 3'h2, 16'h0021, 8'h00, 8'h21, 2'h3},
         '{32'h9a000000, `OAG_M_INH, 3'h1, 16'h0000, 8'h00, 8'h21, 2'h0}};
      rstn = 1'b0;
      startValid = 1'b0;
      startPc = 16'h0000;
      idxX = 8'h00;
      idxY = 8'h05;
      waitCycles = 4'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(negedge sys_clk);
      // Pointer table in page zero, with a word pointer straddling FF
      u_cpuoag_mem_model.mem[16'h0040] = 8'h12;
      u_cpuoag_mem_model.mem[16'h0041] = 8'h34;
      u_cpuoag_mem_model.mem[16'h0050] = 8'hff;
      u_cpuoag_mem_model.mem[16'h00ff] = 8'h80;
      u_cpuoag_mem_model.mem[16'h0100] = 8'h77;
      check({busy, done, memReq, imaskLevel, effAddr}, 0);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < 27; i++)
         run_instr(16'h1000 + 16'(i * 8), rows[i], 1'b0);
      waitCycles = 4'h3;
      run_instr(16'h2000, rows[3], 1'b1);
      // Mask first, so that the level the next row expects stands
      run_instr(16'h2008, rows[8], 1'b0);
      run_instr(16'h2010, rows[19], 1'b1);
      // Reset in mid-fetch, then a clean restart
      startPc = 16'h3000;
      startValid = 1'b1;
      @(negedge sys_clk);
      startValid = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b0;
      @(negedge sys_clk);
      check({busy, done, memReq}, 0);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      waitCycles = 4'h0;
      run_instr(16'h3100, rows[0], 1'b0);
      final_report;
   end
endmodule
